// File: rtl/rx_char_fifo.sv
// small character store with registered head output
`timescale 1ns/1ps
`default_nettype none

module rx_char_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_i,
	input  wire logic             flush_i,
	input  wire logic             push_valid_i,
	output logic                  push_ready_o,
	input  wire logic [WIDTH-1:0] push_data_i,
	output logic                  pop_valid_o,
	input  wire logic             pop_ready_i,
	output logic      [WIDTH-1:0] head_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             do_push;
	logic             do_pop;
	logic [AW-1:0]    rd_nxt;
	logic             fwd;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	assign push_ready_o = (count_r != (AW+1)'(DEPTH));
	assign pop_valid_o  = (count_r != '0);
	assign do_push      = push_valid_i & push_ready_o;
	assign do_pop       = pop_ready_i & pop_valid_o;
	// a character landing in the slot that becomes the head is forwarded, so the
	// head is valid in the same cycle as the pending flag that announces it
	assign rd_nxt       = do_pop ? bump(rd_ptr_r) : rd_ptr_r;
	assign fwd          = do_push & (wr_ptr_r == rd_nxt);

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_r[wr_ptr_r] <= push_data_i;
		end
		head_o <= fwd ? push_data_i : mem_r[rd_nxt];
	end

	always_ff @(posedge clk_i) begin
		if (flush_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= do_push ? bump(wr_ptr_r) : wr_ptr_r;
			rd_ptr_r <= do_pop ? bump(rd_ptr_r) : rd_ptr_r;
			count_r  <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

endmodule : rx_char_fifo

`default_nettype wire

// File: rtl/usart_async_receiver.sv
// asynchronous serial receive path with its control and status registers
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "usart_rx_params.svh"

module usart_async_receiver
	import usart_rx_pkg::*;
#(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rx_pin_i,
	input  wire logic        rx_dir_drive_i,
	output logic             rx_pin_oe_n_o,
	input  wire logic        tx_bit_i,
	input  wire logic        tsr_empty_i,
	output logic             transmit_clock_pin_o,
	output logic             transmit_clock_pin_oe_n_o,
	output logic             sync_shift_o,
	output logic             tx_allowed_o,
	output logic             rx_irq_o
);

	// ------------------------------------------------------------------------
	// register bus decode
	// ------------------------------------------------------------------------
	logic       ack_r;
	logic [7:0] rc_ctl_r;
	logic [7:0] tc_ctl_r;
	logic [7:0] div_r;
	logic [2:0] ien_r;
	logic       overrun_bit_r;

	wire        req       = wb_cyc_i & wb_stb_i;
	wire [5:0]  idx       = wb_adr_i[7:2];
	wire        fire      = req & ack_r;
	wire        wr_fire   = fire & wb_we_i & wb_sel_i[0];
	wire        wr_rc     = wr_fire & (idx == `IDX_RX_CTRL);
	wire        wr_tc     = wr_fire & (idx == `IDX_TX_CTRL);
	wire        wr_div    = wr_fire & (idx == `IDX_BAUD_DIV);
	wire        wr_ic     = wr_fire & (idx == `IDX_IRQ_CTRL);
	wire        rd_data   = fire & ~wb_we_i & (idx == `IDX_RX_DATA);

	wire        serial_port_enable      = rc_ctl_r[`RC_SERIAL_PORT_ENABLE];
	wire        rx9       = rc_ctl_r[`RC_RX9];
	wire        single_receive_enable      = rc_ctl_r[`RC_SINGLE_RECEIVE_ENABLE];
	wire        continuous_receive_enable      = rc_ctl_r[`RC_CONTINUOUS_RECEIVE_ENABLE];
	wire        sync_mode = tc_ctl_r[`TC_SYNC];
	wire        clock_polarity_bit      = tc_ctl_r[`TC_CLOCK_POLARITY_BIT];
	wire        clock_source_bit      = tc_ctl_r[`TC_CLOCK_SOURCE_BIT];
	wire        transmit_enable_bit      = tc_ctl_r[`TC_TRANSMIT_ENABLE_BIT];

	// clearing the port enable resets the baud timer, receiver, character store, overrun flag and sync clock
	wire        unit_rst  = rst_i | ~serial_port_enable;
	wire        rx_en     = serial_port_enable & continuous_receive_enable & ~sync_mode;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= req & ~ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rc_ctl_r <= `RC_RESET;
			tc_ctl_r <= `TC_RESET;
			div_r    <= 8'h00;
			ien_r    <= 3'h0;
		end else begin
			// status bits are not stored; only the writable fields latch
			if (wr_rc) rc_ctl_r <= {wb_dat_i[7:4], 4'h0};
			if (wr_tc) tc_ctl_r <= {wb_dat_i[7:3], 2'h0, wb_dat_i[0]};
			if (wr_div) div_r <= wb_dat_i[7:0];
			if (wr_ic) ien_r <= wb_dat_i[2:0];
		end
	end

	// ------------------------------------------------------------------------
	// baud timer: one tick per sixteenth of a bit
	// ------------------------------------------------------------------------
	logic [7:0] presc_r;
	wire        tick      = (presc_r == div_r);
	wire [7:0]  presc_nxt = (wr_div | tick) ? 8'h00 : presc_r + 8'h01;

	always_ff @(posedge clk_i) begin
		if (unit_rst) begin
			presc_r <= 8'h00;
		end else begin
			presc_r <= presc_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// pin synchroniser and edge detect
	// ------------------------------------------------------------------------
	logic rx_s1_r;
	logic rx_s2_r;
	logic rx_prev_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_s1_r   <= 1'b1;
			rx_s2_r   <= 1'b1;
			rx_prev_r <= 1'b1;
		end else begin
			rx_s1_r   <= rx_pin_i;
			rx_s2_r   <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
		end
	end

	wire fall = rx_prev_r & ~rx_s2_r;

	// ------------------------------------------------------------------------
	// data recovery state machine
	// ------------------------------------------------------------------------
	rx_state_e  state_r;
	rx_state_e  state_nxt;
	logic [3:0] os_cnt_r;
	logic [3:0] bit_idx_r;
	logic [1:0] smp_r;
	logic [8:0] shift_r;

	function automatic logic vote3(input logic a, input logic b, input logic c);
		vote3 = (a & b) | (a & c) | (b & c);
	endfunction : vote3

	wire        decide    = tick & (os_cnt_r == `VOTE_DECIDE);
	wire        vote      = vote3(smp_r[1], smp_r[0], rx_s2_r);
	wire [3:0]  nbits     = rx9 ? `BITS_WIDE : `BITS_NARROW;
	wire        last_bit  = (bit_idx_r == nbits - 4'h1);
	wire        done      = (state_r == RX_STOP) & decide;
	wire [8:0]  char_data = rx9 ? shift_r : {1'b0, shift_r[8:1]};

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RX_IDLE: begin
				if (fall) state_nxt = RX_START;
			end
			RX_START: begin
				// line back high at mid start bit: drop it without error
				if (decide) state_nxt = vote ? RX_IDLE : RX_DATA;
			end
			RX_DATA: begin
				if (decide & last_bit) state_nxt = RX_STOP;
			end
			RX_STOP: begin
				if (decide) state_nxt = RX_IDLE;
			end
			default: state_nxt = RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (unit_rst | ~rx_en) begin
			state_r <= RX_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// the oversample counter restarts on the start edge so mid-bit lands on count 8
	always_ff @(posedge clk_i) begin
		if (state_r == RX_IDLE) begin
			os_cnt_r  <= 4'h0;
			bit_idx_r <= 4'h0;
		end else if (tick) begin
			os_cnt_r <= os_cnt_r + 4'h1;
			if (decide & (state_r == RX_DATA)) bit_idx_r <= bit_idx_r + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (tick & (os_cnt_r >= `VOTE_FIRST) & (os_cnt_r < `VOTE_DECIDE)) begin
			smp_r <= {smp_r[0], rx_s2_r};
		end
		if (decide & (state_r == RX_DATA)) begin
			shift_r <= {vote, shift_r[8:1]};
		end
	end

	// ------------------------------------------------------------------------
	// character store and overrun
	// ------------------------------------------------------------------------
	rx_char_s push_char;
	rx_char_s head_char;
	logic     push_ready;
	logic     pending;

	assign push_char.framing_error_bit = ~vote;
	assign push_char.data = char_data;

	// a framing error never holds reception back
	wire push = done & ~overrun_bit_r;

	rx_char_fifo #(
		.WIDTH ($bits(rx_char_s)),
		.DEPTH (FIFO_DEPTH)
	) u_store (
		.clk_i        (clk_i),
		.flush_i      (unit_rst),
		.push_valid_i (push),
		.push_ready_o (push_ready),
		.push_data_i  (push_char),
		.pop_valid_o  (pending),
		.pop_ready_i  (rd_data),
		.head_o       (head_char)
	);

	wire overrun_bit_set = push & ~push_ready;

	always_ff @(posedge clk_i) begin
		if (unit_rst | ~continuous_receive_enable) begin
			overrun_bit_r <= 1'b0;
		end else if (overrun_bit_set) begin
			overrun_bit_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------------
	wire       framing_error_bit_view = serial_port_enable & pending & head_char.framing_error_bit;
	wire       r9d_view  = pending & head_char.data[8];
	wire       idle_view = (state_r == RX_IDLE);
	wire [7:0] rc_view   = {rc_ctl_r[7:4], idle_view, framing_error_bit_view, overrun_bit_r, r9d_view};
	wire [7:0] tc_view   = {tc_ctl_r[7:3], 1'b0, tsr_empty_i, tc_ctl_r[`TC_TRANSMIT_NINTH_BIT]};
	wire [7:0] ic_view   = {4'h0, pending, ien_r};
	wire [7:0] rd_view   = (idx == `IDX_RX_CTRL)  ? rc_view :
	                       (idx == `IDX_TX_CTRL)  ? tc_view :
	                       (idx == `IDX_BAUD_DIV) ? div_r :
	                       (idx == `IDX_IRQ_CTRL) ? ic_view :
	                       (idx == `IDX_RX_DATA)  ? head_char.data[7:0] : 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req & ~ack_r) begin
			wb_dat_o <= {24'h00_0000, rd_view};
		end
	end

	assign wb_ack_o = ack_r;

	// ------------------------------------------------------------------------
	// pin control, interrupt request and clock pin
	// ------------------------------------------------------------------------
	logic sclk_r;
	wire  rx_force    = serial_port_enable & continuous_receive_enable & ~sync_mode;
	wire  sync_master = serial_port_enable & sync_mode & clock_source_bit;
	wire  sync_rx     = sync_mode & (single_receive_enable | continuous_receive_enable);
	wire  ck_drive    = serial_port_enable & ((~sync_mode & transmit_enable_bit) | sync_master);
	wire  ck_level    = sync_mode ? (sclk_r ^ clock_polarity_bit) : (tx_bit_i ^ clock_polarity_bit);
	wire  irq_nxt     = pending & ien_r[`IC_RECEIVE_INTERRUPT_ENABLE] & ien_r[`IC_PERIPHERAL_INTERRUPT_ENABLE] & ien_r[`IC_GIE];

	always_ff @(posedge clk_i) begin
		if (unit_rst) begin
			sclk_r <= 1'b0;
		end else if (sync_master & tick) begin
			sclk_r <= ~sclk_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_pin_oe_n_o <= 1'b1;
			transmit_clock_pin_o       <= 1'b1;
			transmit_clock_pin_oe_n_o  <= 1'b1;
			sync_shift_o  <= 1'b0;
			tx_allowed_o  <= 1'b0;
			rx_irq_o      <= 1'b0;
		end else begin
			rx_pin_oe_n_o <= rx_force | ~rx_dir_drive_i;
			transmit_clock_pin_o       <= ck_level;
			transmit_clock_pin_oe_n_o  <= ~ck_drive;
			// data changes as the internal clock rises: the pin edge follows polarity
			sync_shift_o  <= sync_master & tick & ~sclk_r;
			tx_allowed_o  <= serial_port_enable & transmit_enable_bit & ~(sync_mode & sync_rx);
			rx_irq_o      <= irq_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_RX_GATED: assert property (~rx_en |=> state_r == RX_IDLE)
		else $error("receiver left idle while disabled");
	AST_IRQ_GATE: assert property (##1 rx_irq_o == $past(irq_nxt))
		else $error("interrupt request does not follow pending and enables");
	AST_FALSE_START: assert property ((state_r == RX_START) && decide && vote && rx_en |=> state_r == RX_IDLE)
		else $error("false start bit not dropped");
	AST_OVR_SET: assert property (overrun_bit_set && continuous_receive_enable && serial_port_enable |=> overrun_bit_r)
		else $error("overrun not flagged on full store");
	AST_OVR_REFUSE: assert property (overrun_bit_r && serial_port_enable && ~rd_data |=> $stable({pending, push_ready}))
		else $error("character accepted during overrun");
	AST_OVR_CLR: assert property (~continuous_receive_enable |=> ~overrun_bit_r)
		else $error("overrun survives receive disable");
	AST_FRAMING_ERROR_BIT_OFF: assert property (~serial_port_enable |=> ##1 ~rc_view[`RC_FRAMING_ERROR_BIT])
		else $error("framing bit set while port disabled");
	AST_PIN_INPUT: assert property (rx_force |=> rx_pin_oe_n_o)
		else $error("receive pin driven while receiving");
	AST_BAUD_RESTART: assert property (wr_div && serial_port_enable |=> presc_r == 8'h00)
		else $error("divisor write did not restart baud timer");
	AST_PENDING: assert property (push && push_ready && serial_port_enable |=> ic_view[`IC_PEND])
		else $error("pending flag not raised by a stored character");
	AST_DATA_LEN: assert property ((state_r == RX_DATA) && decide && last_bit && rx_en |=> state_r == RX_STOP
		&& bit_idx_r == nbits)
		else $error("wrong number of data bits");

	COV_CHAR: cover property (push && ~push_char.framing_error_bit);
	COV_FRAMING_ERROR_BIT: cover property (push && push_char.framing_error_bit);
	COV_OVR: cover property (overrun_bit_set);
	COV_FALSE: cover property ((state_r == RX_START) && decide && vote);

endmodule : usart_async_receiver

`default_nettype wire

// File: rtl/usart_rx_params.svh
// register offsets, field positions, reset values and timing counts of the receiver
`ifndef USART_RX_PARAMS_SVH
`define USART_RX_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_RX_CTRL      6'h18
`define IDX_BAUD_DIV     6'h19
`define IDX_RX_DATA      6'h1A
`define IDX_IRQ_CTRL     6'h1B
`define IDX_TX_CTRL      6'h1E

// ----------------------------------------------------------------------------
// receive_control_status fields
// ----------------------------------------------------------------------------
`define RC_SERIAL_PORT_ENABLE          7
`define RC_RX9           6
`define RC_SINGLE_RECEIVE_ENABLE          5
`define RC_CONTINUOUS_RECEIVE_ENABLE          4
`define RC_IDLE          3
`define RC_FRAMING_ERROR_BIT          2
`define RC_OVERRUN_BIT          1
`define RC_RECEIVE_NINTH_BIT          0
`define RC_RESET         8'h08

// ----------------------------------------------------------------------------
// transmit_control_status fields
// ----------------------------------------------------------------------------
`define TC_CLOCK_SOURCE_BIT          7
`define TC_TX9           6
`define TC_TRANSMIT_ENABLE_BIT          5
`define TC_SYNC          4
`define TC_CLOCK_POLARITY_BIT          3
`define TC_SHIFTER_EMPTY_BIT          1
`define TC_TRANSMIT_NINTH_BIT          0
`define TC_RESET         8'h02

// ----------------------------------------------------------------------------
// interrupt control fields and timing
// ----------------------------------------------------------------------------
`define IC_RECEIVE_INTERRUPT_ENABLE          0
`define IC_PERIPHERAL_INTERRUPT_ENABLE          1
`define IC_GIE           2
`define IC_PEND          3
`define OVERSAMPLE       16
`define VOTE_FIRST       4'h7
`define VOTE_DECIDE      4'h9
`define BITS_NARROW      4'h8
`define BITS_WIDE        4'h9

`endif

// File: rtl/usart_rx_pkg.sv
// types shared by the asynchronous receiver and its character store
package usart_rx_pkg;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} rx_state_e;

	typedef struct packed {
		logic       framing_error_bit;
		logic [8:0] data;
	} rx_char_s;

endpackage : usart_rx_pkg

// File: verif/serial_tx_model.sv
// remote asynchronous serial transmitter that drives the receive pin
`timescale 1ns/1ps
`default_nettype none

module serial_tx_model (
	input  wire logic clk_i,
	output logic      line_o
);
	// ------------------------------------------------------------------
	// line control
	// ------------------------------------------------------------------
	// the line rests in the mark state between frames
	initial line_o = 1'b1;

	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold

	// one frame; the stop level is the caller's, so broken frames can be sent
	task automatic send_char(input logic [8:0] d, input int nbits, input logic stop_lvl, input int bit_clks);
		@(posedge clk_i);
		line_o <= 1'b0;
		hold(bit_clks);
		for (int i = 0; i < nbits; i++) begin
			line_o <= d[i];
			hold(bit_clks);
		end
		line_o <= stop_lvl;
		hold(bit_clks);
		line_o <= 1'b1;
		hold(bit_clks);
	endtask : send_char

	// a low pulse shorter than half a bit, as noise on an idle line would give
	task automatic glitch(input int n, input int bit_clks);
		@(posedge clk_i);
		line_o <= 1'b0;
		hold(n);
		line_o <= 1'b1;
		hold(2 * bit_clks);
	endtask : glitch
endmodule : serial_tx_model
`default_nettype wire

// File: verif/testbench.sv
// self-checking bench for the asynchronous receiver and its registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int BIT = 16;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        rx_pin;
	logic        rx_pin_oe_n_o;
	logic        tx_bit_i = 1'b1;
	logic        transmit_clock_pin_o;
	logic        transmit_clock_pin_oe_n_o;
	logic        rx_irq_o;
	logic        sync_shift_o;
	logic        tx_allowed_o;
	int          n_errors = 0;
	int          compares = 0;

	always #12.5 clk_i = ~clk_i;

	usart_async_receiver dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.rx_pin_i(rx_pin), .rx_dir_drive_i(1'b1), .rx_pin_oe_n_o(rx_pin_oe_n_o), .tx_bit_i(tx_bit_i),
		.tsr_empty_i(1'b1), .transmit_clock_pin_o(transmit_clock_pin_o), .transmit_clock_pin_oe_n_o(transmit_clock_pin_oe_n_o), .sync_shift_o(sync_shift_o),
		.tx_allowed_o(tx_allowed_o), .rx_irq_o(rx_irq_o)
	);

	serial_tx_model model (.clk_i(clk_i), .line_o(rx_pin));

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic complete_run();
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// classic single cycle; a missing ack ends the run
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
		int n;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			n_errors++;
			complete_run();
		end
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] rd;
		wb(1'b1, a, d, rd);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		wb(1'b0, a, 8'h00, rd);
		check(rd, exp);
	endtask : rd_chk

	task automatic send(input logic [8:0] d);
		model.send_char(d, 8, 1'b1, BIT);
	endtask : send

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		rd_chk(8'h60, 32'h08);
		rd_chk(8'h78, 32'h02);
		wr(8'h40, 8'hFF);
		rd_chk(8'h40, 32'h00);
		rd_chk(8'h6C, 32'h00);
	endtask : t_reset

	task automatic t_basic();
		wr(8'h6C, 8'h07);
		// port off: the direction setting owns the pin
		check({31'h0, rx_pin_oe_n_o}, 32'h0);
		wr(8'h60, 8'h90);
		repeat (2) @(posedge clk_i);
		check({31'h0, rx_pin_oe_n_o}, 32'h1);
		send(9'h0A5);
		rd_chk(8'h6C, 32'h0F);
		check({31'h0, rx_irq_o}, 32'h1);
		rd_chk(8'h68, 32'hA5);
		rd_chk(8'h6C, 32'h07);
		check({31'h0, rx_irq_o}, 32'h0);
		// global enable off: flag stays, request is masked
		wr(8'h6C, 8'h03);
		send(9'h05A);
		rd_chk(8'h6C, 32'h0B);
		check({31'h0, rx_irq_o}, 32'h0);
		wr(8'h6C, 8'h07);
		repeat (3) @(posedge clk_i);
		check({31'h0, rx_irq_o}, 32'h1);
		rd_chk(8'h68, 32'h5A);
	endtask : t_basic

	task automatic t_idle_busy();
		fork
			send(9'h0F0);
			begin
				repeat (3 * BIT) @(posedge clk_i);
				rd_chk(8'h60, 32'h90);
			end
		join
		rd_chk(8'h60, 32'h98);
		rd_chk(8'h68, 32'hF0);
		model.glitch(5, BIT);
		rd_chk(8'h6C, 32'h07);
	endtask : t_idle_busy

	task automatic t_framing();
		model.send_char(9'h03C, 8, 1'b0, BIT);
		send(9'h0C3);
		rd_chk(8'h60, 32'h9C);
		rd_chk(8'h68, 32'h3C);
		rd_chk(8'h60, 32'h98);
		rd_chk(8'h68, 32'hC3);
		// port disable clears a pending framing error and flushes the store
		model.send_char(9'h000, 8, 1'b0, BIT);
		wr(8'h60, 8'h10);
		rd_chk(8'h60, 32'h18);
		wr(8'h60, 8'h90);
		rd_chk(8'h6C, 32'h07);
	endtask : t_framing

	task automatic t_overrun();
		send(9'h011);
		send(9'h022);
		send(9'h033);
		rd_chk(8'h60, 32'h9A);
		rd_chk(8'h68, 32'h11);
		rd_chk(8'h68, 32'h22);
		send(9'h044);
		rd_chk(8'h6C, 32'h07);
		wr(8'h60, 8'h80);
		rd_chk(8'h60, 32'h88);
		wr(8'h60, 8'h90);
		send(9'h055);
		rd_chk(8'h68, 32'h55);
	endtask : t_overrun

	task automatic t_modes();
		wr(8'h60, 8'hD0);
		model.send_char(9'h1A5, 9, 1'b1, BIT);
		rd_chk(8'h60, 32'hD9);
		rd_chk(8'h68, 32'hA5);
		wr(8'h60, 8'h90);
		// divisor 1 doubles the bit time
		wr(8'h64, 8'h01);
		model.send_char(9'h05A, 8, 1'b1, 2 * BIT);
		rd_chk(8'h68, 32'h5A);
		wr(8'h64, 8'h00);
		// synchronous mode selected: asynchronous reception is off
		wr(8'h78, 8'h10);
		send(9'h066);
		rd_chk(8'h6C, 32'h07);
		wr(8'h78, 8'h00);
	endtask : t_modes

	task automatic t_tx_pin();
		wr(8'h78, 8'h28);
		@(posedge clk_i);
		tx_bit_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		check({31'h0, transmit_clock_pin_o}, 32'h1);
		check({31'h0, transmit_clock_pin_oe_n_o}, 32'h0);
		tx_bit_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		check({31'h0, transmit_clock_pin_o}, 32'h0);
		wr(8'h78, 8'h00);
	endtask : t_tx_pin

	// synchronous master: clock ownership, change edge per polarity, receive precedence
	task automatic t_sync();
		int n;
		for (int s = 0; s < 2; s++) begin
			wr(8'h78, (s == 1) ? 8'hB8 : 8'hB0);
			repeat (2) @(posedge clk_i);
			check({31'h0, tx_allowed_o}, 32'h0);
			check({31'h0, transmit_clock_pin_oe_n_o}, 32'h0);
			n = 0;
			while (sync_shift_o !== 1'b1 && n < 8) begin
				@(posedge clk_i);
				n++;
			end
			check({31'h0, sync_shift_o}, 32'h1);
			check({31'h0, transmit_clock_pin_o}, (s == 1) ? 32'h1 : 32'h0);
			@(posedge clk_i);
			check({31'h0, transmit_clock_pin_o}, (s == 1) ? 32'h0 : 32'h1);
		end
		wr(8'h60, 8'h80);
		repeat (2) @(posedge clk_i);
		check({31'h0, tx_allowed_o}, 32'h1);
		wr(8'h78, 8'h30);
		repeat (2) @(posedge clk_i);
		check({31'h0, transmit_clock_pin_oe_n_o}, 32'h1);
		wr(8'h78, 8'h00);
	endtask : t_sync

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_basic();
		t_idle_busy();
		t_framing();
		t_overrun();
		t_modes();
		t_tx_pin();
		t_sync();
		complete_run();
	end
endmodule : testbench
`default_nettype wire
